/* design/aulsc_pkg.sv */
// Package: register map, field layout and encodings of the upper-limit supervision block
package aulsc_pkg;
  localparam int unsigned aulsc_num_chan = 16;
  localparam logic [7:0] aulsc_off_diff_level = 8'hd4;
  localparam logic [7:0] aulsc_off_cnt0_3 = 8'he8;
  localparam logic [7:0] aulsc_off_cnt4_7 = 8'hec;
  localparam logic [7:0] aulsc_off_cnt8_11 = 8'hf0;
  localparam logic [7:0] aulsc_off_diff_cnt = 8'hf4;
  localparam logic [7:0] aulsc_off_level8_11 = 8'hc0;
  localparam logic [7:0] aulsc_off_level0_3 = 8'hc4;
  localparam logic [7:0] aulsc_off_level4_7 = 8'hc8;
  localparam logic [7:0] aulsc_off_irq_status = 8'h00;
  localparam logic [7:0] aulsc_off_irq_mask = 8'h04;
  localparam logic [7:0] aulsc_off_event_state = 8'h08;
  localparam logic [31:0] aulsc_rst_diff_level = 32'h0000_0000;
  localparam logic [31:0] aulsc_rst_cnt0_3 = 32'h1213_1b1a;
  localparam logic [31:0] aulsc_rst_cnt4_7 = 32'h0000_0000;
  localparam logic [31:0] aulsc_rst_cnt8_11 = 32'h0000_0000;
  localparam logic [31:0] aulsc_rst_diff_cnt = 32'h0000_0000;
  localparam logic [31:0] aulsc_rst_level = 32'h0000_0000;
  localparam logic [31:0] aulsc_rst_zero = 32'h0000_0000;
  localparam logic [7:0] aulsc_lane_mask = 8'h1f;
  localparam int unsigned aulsc_hyst_lsb = 3;
  localparam int unsigned aulsc_cnt_lsb = 0;
  localparam logic [1:0] aulsc_resp_okay = 2'h0;
  localparam logic [1:0] aulsc_resp_slverr = 2'h2;
  typedef enum logic [1:0] {
    hysteresis_off,
    hysteresis_four,
    hysteresis_eight,
    hysteresis_sixteen
  } aulsc_hyst_type;
  localparam logic [4:0] aulsc_hyst_val_off = 5'h00;
  localparam logic [4:0] aulsc_hyst_val_four = 5'h04;
  localparam logic [4:0] aulsc_hyst_val_eight = 5'h08;
  localparam logic [4:0] aulsc_hyst_val_sixteen = 5'h10;
  localparam logic [5:0] aulsc_meas_max = 6'h3f;
endpackage

/* design/aulsc_decode.sv */
// Decoders for the hysteresis and count codes of one channel
`timescale 1ns/10ps
`default_nettype none
module aulsc_decode
  import aulsc_pkg::*;
(
  input wire logic [1:0] hyst_code,
  input wire logic [2:0] count_code,
  output logic [4:0] hyst_value,
  output logic [5:0] meas_needed
);
  import aulsc_pkg::*;
  always_comb begin
    case (aulsc_hyst_type'(hyst_code))
      hysteresis_off: hyst_value = aulsc_hyst_val_off;
      hysteresis_four: hyst_value = aulsc_hyst_val_four;
      hysteresis_eight: hyst_value = aulsc_hyst_val_eight;
      hysteresis_sixteen: hyst_value = aulsc_hyst_val_sixteen;
      default: hyst_value = aulsc_hyst_val_off;
    endcase
  end
  // Codes 6 and 7 both saturate at 63 so the count fits six bits
  assign meas_needed = (count_code >= 3'h6) ? aulsc_meas_max :
    6'(6'h01 << count_code);
endmodule
`default_nettype wire

/* design/aulsc_channel.sv */
// One channel's upper-limit debounce and hysteresis release
`timescale 1ns/10ps
`default_nettype none
module aulsc_channel
  import aulsc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic result_valid,
  input wire logic [9:0] result,
  input wire logic [7:0] level,
  input wire logic [1:0] hyst_code,
  input wire logic [2:0] count_code,
  output logic event_active
);
  import aulsc_pkg::*;
  logic [4:0] hyst_value;
  logic [5:0] meas_needed;
  logic [5:0] run;
  logic [5:0] next_run;
  logic next_event;
  wire above = result[9:2] > level;
  wire [8:0] release_level = {1'b0, level} - {4'h0, hyst_value};
  wire below = release_level[8] ? 1'b0 :
    ({1'b0, result[9:2]} < release_level);
  aulsc_decode u_dec (
    .hyst_code(hyst_code),
    .count_code(count_code),
    .hyst_value(hyst_value),
    .meas_needed(meas_needed)
  );
  // Only the top eight result bits are compared against the 8-bit level
  assign next_run = !result_valid ? run :
    (above ? ((run < meas_needed) ? run + 6'h01 : run) : 6'h00);
  assign next_event = !result_valid ? event_active :
    (event_active ? !below : (next_run >= meas_needed));
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      run <= 6'h00;
      event_active <= 1'b0;
    end else begin
      run <= next_run;
      event_active <= next_event;
    end
  end
endmodule
`default_nettype wire

/* design/aulsc_top.sv */
// Upper-limit supervision registers, channel supervisors and AXI4-Lite slave
//
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module aulsc_top
  import aulsc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic result_valid,
  input wire logic [3:0] result_chan,
  input wire logic [9:0] result,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [aulsc_pkg::aulsc_num_chan-1:0] upper_event,
  output logic irq
);
  import aulsc_pkg::*;
  localparam int unsigned n = aulsc_num_chan;

  logic rst_meta;
  logic rst_n;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // Configuration storage
  logic [31:0] level0_3;
  logic [31:0] level4_7;
  logic [31:0] level8_11;
  logic [31:0] diff_level;
  logic [31:0] cnt0_3;
  logic [31:0] cnt4_7;
  logic [31:0] cnt8_11;
  logic [31:0] diff_cnt;
  logic [n-1:0] irq_status;
  logic [n-1:0] irq_mask;
  logic [n-1:0] event_now;
  logic [n-1:0] event_prev;

  // Result inputs come from the converter on this clock: no synchroniser
  logic [31:0] levels_all [4];
  logic [31:0] counts_all [4];
  assign levels_all[0] = level0_3;
  assign levels_all[1] = level4_7;
  assign levels_all[2] = level8_11;
  assign levels_all[3] = diff_level;
  assign counts_all[0] = cnt0_3;
  assign counts_all[1] = cnt4_7;
  assign counts_all[2] = cnt8_11;
  assign counts_all[3] = diff_cnt;

  // Channels 12 to 15 are differential channels 1 to 4
  for (genvar c = 0; c < n; c++) begin : g_chan
    wire [31:0] lv = levels_all[c / 4];
    wire [31:0] ct = counts_all[c / 4];
    aulsc_channel u_chan (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .result_valid(result_valid && (result_chan == 4'(c))),
      .result(result),
      .level(lv[8*(c%4) +: 8]),
      .hyst_code(ct[8*(c%4) + aulsc_hyst_lsb +: 2]),
      .count_code(ct[8*(c%4) + aulsc_cnt_lsb +: 3]),
      .event_active(event_now[c])
    );
  end

  // Write channel: address and data taken in either order
  // Ready flags are flops so every bus output leaves a register
  wire aw_held = !s_axi_awready;
  wire w_held = !s_axi_wready;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire wr_go = aw_held && w_held && !s_axi_bvalid;
  wire [31:0] bmask = {{8{w_strb[3]}}, {8{w_strb[2]}},
    {8{w_strb[1]}}, {8{w_strb[0]}}};
  wire [31:0] lane_keep = {4{aulsc_lane_mask}};
  wire [31:0] w_cnt_mask = bmask & lane_keep;
  wire wr_level0 = wr_go && aw_addr == aulsc_off_level0_3;
  wire wr_level4 = wr_go && aw_addr == aulsc_off_level4_7;
  wire wr_level8 = wr_go && aw_addr == aulsc_off_level8_11;
  wire wr_dlevel = wr_go && aw_addr == aulsc_off_diff_level;
  wire wr_cnt0 = wr_go && aw_addr == aulsc_off_cnt0_3;
  wire wr_cnt4 = wr_go && aw_addr == aulsc_off_cnt4_7;
  wire wr_cnt8 = wr_go && aw_addr == aulsc_off_cnt8_11;
  wire wr_dcnt = wr_go && aw_addr == aulsc_off_diff_cnt;
  wire wr_stat = wr_go && aw_addr == aulsc_off_irq_status;
  wire wr_mask = wr_go && aw_addr == aulsc_off_irq_mask;
  wire wr_hit = wr_level0 || wr_level4 || wr_level8 || wr_dlevel ||
    wr_cnt0 || wr_cnt4 || wr_cnt8 || wr_dcnt || wr_stat || wr_mask ||
    (aw_addr == aulsc_off_event_state);

  function automatic logic [31:0] merge(input logic [31:0] old,
    input logic [31:0] data, input logic [31:0] m);
    merge = (old & ~m) | (data & m);
  endfunction
  wire [31:0] mask_word = merge(32'(irq_mask), w_data, bmask);
  wire [31:0] clr_word = merge(aulsc_rst_zero, w_data, bmask);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      aw_addr <= 8'h00;
      w_data <= aulsc_rst_zero;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= aulsc_resp_okay;
    end else begin
      if (aw_take) begin
        s_axi_awready <= 1'b0;
        aw_addr <= {s_axi_awaddr[7:2], 2'h0};
      end else if (wr_go) begin
        s_axi_awready <= 1'b1;
      end
      if (w_take) begin
        s_axi_wready <= 1'b0;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (wr_go) begin
        s_axi_wready <= 1'b1;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? aulsc_resp_okay : aulsc_resp_slverr;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      level0_3 <= aulsc_rst_level;
      level4_7 <= aulsc_rst_level;
      level8_11 <= aulsc_rst_level;
      diff_level <= aulsc_rst_diff_level;
      cnt0_3 <= aulsc_rst_cnt0_3;
      cnt4_7 <= aulsc_rst_cnt4_7;
      cnt8_11 <= aulsc_rst_cnt8_11;
      diff_cnt <= aulsc_rst_diff_cnt;
      irq_mask <= '0;
    end else begin
      if (wr_level0) level0_3 <= merge(level0_3, w_data, bmask);
      if (wr_level4) level4_7 <= merge(level4_7, w_data, bmask);
      if (wr_level8) level8_11 <= merge(level8_11, w_data, bmask);
      if (wr_dlevel) diff_level <= merge(diff_level, w_data, bmask);
      if (wr_cnt0) cnt0_3 <= merge(cnt0_3, w_data, w_cnt_mask);
      if (wr_cnt4) cnt4_7 <= merge(cnt4_7, w_data, w_cnt_mask);
      if (wr_cnt8) cnt8_11 <= merge(cnt8_11, w_data, w_cnt_mask);
      if (wr_dcnt) diff_cnt <= merge(diff_cnt, w_data, w_cnt_mask);
      if (wr_mask) irq_mask <= mask_word[n-1:0];
    end
  end

  // Status sets on event rise; a set in the clear cycle wins
  wire [n-1:0] rise = event_now & ~event_prev;
  wire [n-1:0] clr = wr_stat ? clr_word[n-1:0] : '0;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      event_prev <= '0;
      irq_status <= '0;
      upper_event <= '0;
      irq <= 1'b0;
    end else begin
      event_prev <= event_now;
      irq_status <= (irq_status & ~clr) | rise;
      upper_event <= event_now;
      irq <= |(((irq_status & ~clr) | rise) & irq_mask);
    end
  end

  // Read channel
  logic [31:0] rd_word;
  logic rd_ok;
  wire [7:0] ra = {s_axi_araddr[7:2], 2'h0};
  always_comb begin
    rd_ok = 1'b1;
    case (ra)
      aulsc_off_level0_3: rd_word = level0_3;
      aulsc_off_level4_7: rd_word = level4_7;
      aulsc_off_level8_11: rd_word = level8_11;
      aulsc_off_diff_level: rd_word = diff_level;
      aulsc_off_cnt0_3: rd_word = cnt0_3 & lane_keep;
      aulsc_off_cnt4_7: rd_word = cnt4_7 & lane_keep;
      aulsc_off_cnt8_11: rd_word = cnt8_11 & lane_keep;
      aulsc_off_diff_cnt: rd_word = diff_cnt & lane_keep;
      aulsc_off_irq_status: rd_word = 32'(irq_status);
      aulsc_off_irq_mask: rd_word = 32'(irq_mask);
      aulsc_off_event_state: rd_word = 32'(event_now);
      default: begin
        rd_word = aulsc_rst_zero;
        rd_ok = 1'b0;
      end
    endcase
  end
  wire ar_take = s_axi_arvalid && s_axi_arready;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
      s_axi_rdata <= aulsc_rst_zero;
      s_axi_rresp <= aulsc_resp_okay;
    end else if (ar_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_arready <= 1'b0;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_ok ? aulsc_resp_okay : aulsc_resp_slverr;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule
`default_nettype wire

/* test/aulsc_top_sva.sv */
// Checker: bus handshakes, reserved read bits and event timing
`timescale 1ns/10ps
`default_nettype none
module aulsc_sva (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic result_valid,
  input wire logic [3:0] result_chan,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [aulsc_pkg::aulsc_num_chan-1:0] upper_event
);
  logic [7:0] ra;
  wire cnt_reg = (ra >= 8'he8) && (ra <= 8'hf4);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);
  // Address of the read in flight, stable while rvalid stands
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) ra <= 8'h00;
    else if (s_axi_arvalid && s_axi_arready) ra <= s_axi_araddr;
  end
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("bvalid dropped early");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("rvalid dropped early");
  property p_ar_rdy;
    s_axi_arready == !s_axi_rvalid;
  endproperty
  a_ar_rdy: assert property (p_ar_rdy) else $error("arready wrong");
  property p_ar_resp;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_ar_resp: assert property (p_ar_resp) else $error("read answer late");
  property p_b_after;
    $rose(s_axi_bvalid) |-> $past(!s_axi_awready && !s_axi_wready);
  endproperty
  a_b_after: assert property (p_b_after) else $error("bvalid too early");
  property p_rsv;
    s_axi_rvalid && cnt_reg |-> (s_axi_rdata & 32'he0e0e0e0) == 32'h0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits set");
  property p_ev_set;
    |(upper_event & ~$past(upper_event)) |-> $past(result_valid, 2) &&
      (upper_event & ~$past(upper_event)) == (16'h1 << $past(result_chan, 2));
  endproperty
  a_ev_set: assert property (p_ev_set) else $error("event set");
  property p_ev_clr;
    |(~upper_event & $past(upper_event)) |-> $past(result_valid, 2);
  endproperty
  a_ev_clr: assert property (p_ev_clr) else $error("event clear");
  c_ev: cover property ($rose(upper_event[8]));
  c_rsv: cover property (s_axi_rvalid && cnt_reg);
  c_b: cover property ($rose(s_axi_bvalid));
endmodule
bind aulsc_top aulsc_sva aulsc_sva_i (.clk_sys(clk_sys), .nrst(nrst),
  .result_valid(result_valid), .result_chan(result_chan),
  .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .upper_event(upper_event));
`default_nettype wire

/* test/tb_aulsc_top.sv */
// Testbench: register access, reset values, debounce and hysteresis
`timescale 1ns/10ps
`default_nettype none
module tb_aulsc_top;
  import aulsc_pkg::*;
  logic clk_sys = 1'b0, nrst = 1'b0, rv = 1'b0, awv = 1'b0, wv = 1'b0;
  logic bry = 1'b0, arv = 1'b0, rry = 1'b0;
  logic [3:0] rc = 4'h0, ws = 4'hf;
  logic [9:0] res = 10'h000;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rd, v;
  logic awr, wrd, bv, arr, rvl, irq;
  logic [1:0] br, rr;
  logic [15:0] ue;
  int bad_count = 0, n_checks = 0, cyc = 0;
  logic [31:0] rq[$];
  logic [1:0] rsq[$], bq[$];
  logic [5:0] need [8] = '{6'd1, 6'd2, 6'd4, 6'd8, 6'd16, 6'd32, 6'd63, 6'd63};
  logic [7:0] hv [4] = '{8'd0, 8'd4, 8'd8, 8'd16};
  logic [7:0] cofs [4] = '{8'he8, 8'hec, 8'hf0, 8'hf4};
  always #10 clk_sys = ~clk_sys;
  aulsc_top aulsc_top_i (.clk_sys(clk_sys), .nrst(nrst),
    .result_valid(rv), .result_chan(rc), .result(res),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
    .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv),
    .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr),
    .s_axi_rvalid(rvl), .s_axi_rready(rry), .upper_event(ue), .irq(irq));
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Handshakes judged at the negedge, so the posedge never races the design
  task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] e);
    logic ha, hw, hb;
    @(posedge clk_sys);
    bq.push_back(e);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    do begin
      @(negedge clk_sys);
      ha = awv && awr;
      hw = wv && wrd;
      hb = bv && bry;
      @(posedge clk_sys);
      if (ha) awv <= 1'b0;
      if (hw) wv <= 1'b0;
    end while (!hb);
    bry <= 1'b0;
  endtask
  task automatic rdx(logic [7:0] a, logic [31:0] e, logic [1:0] er);
    logic ha, hr;
    @(posedge clk_sys);
    rq.push_back(e);
    rsq.push_back(er);
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    do begin
      @(negedge clk_sys);
      ha = arv && arr;
      hr = rvl && rry;
      @(posedge clk_sys);
      if (ha) arv <= 1'b0;
    end while (!hr);
    rry <= 1'b0;
  endtask
  always @(negedge clk_sys) begin
    if (bv && bry) chk("bresp", 32'(bq.pop_front()), 32'(br));
    if (rvl && rry) begin
      chk("rdata", rq.pop_front(), rd);
      chk("rresp", 32'(rsq.pop_front()), 32'(rr));
    end
  end
  // Event output lands one edge after the result is taken
  task automatic pulse(logic [3:0] c, logic [7:0] top);
    @(posedge clk_sys);
    rv <= 1'b1;
    rc <= c;
    res <= {top, 2'($urandom)};
    @(posedge clk_sys);
    rv <= 1'b0;
    repeat (2) @(negedge clk_sys);
  endtask
  task automatic report_and_stop;
    if (bad_count == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      report_and_stop();
    end
  end
  initial begin
    void'($urandom(32'h1079));
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rdx(8'he8, 32'h1213_1b1a, aulsc_resp_okay);
    rdx(8'hd4, 32'h0, aulsc_resp_okay);
    rdx(8'hc0, 32'h0, aulsc_resp_okay);
    v = $urandom;
    wr(8'hc0, v, aulsc_resp_okay);
    rdx(8'hc0, v, aulsc_resp_okay);
    wr(8'hd4, 32'hff00_ff00, aulsc_resp_okay);
    rdx(8'hd4, 32'hff00_ff00, aulsc_resp_okay);
    for (int i = 0; i < 4; i++) begin
      rdx(cofs[i], (i == 0) ? 32'h1213_1b1a : 32'h0, aulsc_resp_okay);
      wr(cofs[i], 32'hffff_ffff, aulsc_resp_okay);
      rdx(cofs[i], 32'h1f1f_1f1f, aulsc_resp_okay);
    end
    wr(8'h80, v, aulsc_resp_slverr);
    rdx(8'h80, 32'h0, aulsc_resp_slverr);
    wr(8'hc0, 32'h0000_0080, aulsc_resp_okay);
    for (int k = 0; k < 8; k++) begin
      wr(8'hf0, 32'(k), aulsc_resp_okay);
      for (int n = 1; n <= int'(need[k]); n++) begin
        pulse(4'h8, 8'h81);
        chk("upper_event", (n == int'(need[k])) ? 32'h100 : 32'h0, 32'(ue));
      end
      pulse(4'h8, 8'h7f);
      chk("upper_event", 32'h0, 32'(ue));
    end
    for (int k = 0; k < 4; k++) begin
      wr(8'hf0, 32'(k) << 3, aulsc_resp_okay);
      pulse(4'h8, 8'h80);
      chk("upper_event", 32'h0, 32'(ue));
      pulse(4'h8, 8'hff);
      chk("upper_event", 32'h100, 32'(ue));
      pulse(4'h8, 8'h80 - hv[k]);
      chk("upper_event", 32'h100, 32'(ue));
      pulse(4'h8, 8'h7f - hv[k]);
      chk("upper_event", 32'h0, 32'(ue));
    end
    chk("irq", 32'h0, 32'(irq));
    wr(8'h04, 32'h100, aulsc_resp_okay);
    repeat (2) @(negedge clk_sys);
    chk("irq", 32'h1, 32'(irq));
    wr(8'h00, 32'h100, aulsc_resp_okay);
    repeat (2) @(negedge clk_sys);
    chk("irq", 32'h0, 32'(irq));
    rdx(8'h00, 32'h0, aulsc_resp_okay);
    wr(8'hf4, 32'h0, aulsc_resp_okay);
    // Top-byte strobe only: the channel 8 level must survive
    ws <= 4'h8;
    wr(8'hc0, 32'h4000_0000, aulsc_resp_okay);
    ws <= 4'hf;
    rdx(8'hc0, 32'h4000_0080, aulsc_resp_okay);
    // Event rise lands in the same cycle as the clear: the set must win
    fork
      wr(8'h00, 32'h800, aulsc_resp_okay);
      pulse(4'hb, 8'h41);
    join
    @(negedge clk_sys);
    chk("upper_event", 32'h800, 32'(ue));
    rdx(8'h00, 32'h800, aulsc_resp_okay);
    pulse(4'hc, 8'h01);
    chk("upper_event", 32'h1800, 32'(ue));
    rdx(8'h08, 32'h1800, aulsc_resp_okay);
    rdx(8'h04, 32'h100, aulsc_resp_okay);
    report_and_stop();
  end
endmodule
`default_nettype wire
